// file: common/p8c_regs.svh
// Header of strap codes, select levels and timing counts for the port 8 clock and mode select
`ifndef P8C_REGS_SVH
`define P8C_REGS_SVH

// Link speed strap codes, two address-pin straps
`define P8C_SPD_100M      2'h3
`define P8C_SPD_200M      2'h2
`define P8C_SPD_300M      2'h1
`define P8C_SPD_400M      2'h0
// Interface type strap levels
`define P8C_IF_MII        1'h1
`define P8C_IF_SERIAL     1'h0
// Speed and duplex select levels
`define P8C_SPEED_100     1'h1
`define P8C_SPEED_10      1'h0
`define P8C_DUPLEX_FULL   1'h1
`define P8C_DUPLEX_HALF   1'h0
// Reference clock divider from the RMII clock
`define P8C_REF_DIV       2
// Missing-clock watchdog on the supplied reference, in system clocks
`define P8C_REF_TIMEOUT_NS 200
`define P8C_REF_TIMEOUT_CYC ((`P8C_REF_TIMEOUT_NS + 3) / 4)

`endif

// file: common/p8c_pkg.sv
// Package of types for the port 8 clock and mode select
package p8c_pkg;
  // Link speed selection as strapped
  typedef enum logic [1:0] {
    P8C_X1 = 2'h3,
    P8C_X2 = 2'h2,
    P8C_X3 = 2'h1,
    P8C_X4 = 2'h0
  } p8c_speed_t;
  // Reference clock pin direction state, one-hot
  typedef enum logic [1:0] {
    P8C_DRIVE = 2'h1,
    P8C_SENSE = 2'h2
  } p8c_dir_t;
endpackage

// file: rtl/p8c_edge.sv
// Edge detector for the RMII clock and the supplied port 8 reference clock, with a two-stage synchroniser
`timescale 1ns/1ns
module p8c_edge (
  input  wire logic clk_sys_i,  // System clock
  input  wire logic rst_i,      // Synchronous reset
  input  wire logic level_i,    // Raw input level
  output logic      rise_o      // One-cycle pulse per rising edge
);
  logic meta;   // First synchroniser stage
  logic sync;   // Second synchroniser stage
  logic last;   // Delayed copy for edge detection

  // Synchronise and delay
  // Reset to the pulled-up idle level, so a high pin gives no false edge after reset
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      meta   <= 1'h1;
      sync   <= 1'h1;
      last   <= 1'h1;
      rise_o <= 1'h0;
    end else begin
      meta   <= level_i;
      sync   <= meta;
      last   <= sync;
      rise_o <= sync & ~last;
    end
  end
endmodule

// file: rtl/p8c_refclk_mode.sv
// Port 8 reference clock direction, divider and speed and duplex select
// What this block does
// - Regular mode: drive reference clock at RMII/2
// - Speed-up mode: reference pin input, MAC clock source
// - Speed select high means 100 Mbps
// - Duplex select low half, high full
// - Speed straps 11/10/01/00 give 100..400 Mbps
// - Interface strap high MII, low serial
`timescale 1ns/1ns
`include "p8c_regs.svh"
module p8c_refclk_mode (
  input  wire logic              clk_sys_i,           // System clock, 250 MHz
  input  wire logic              rst_i,               // Synchronous reset, active high
  input  wire logic              rmii_clk_i,          // RMII reference clock level, sampled
  input  wire logic [1:0]        strap_speed_i,       // Link speed straps
  input  wire logic              strap_mii_i,         // Interface type strap
  input  wire logic              port8_ref_clock_i,   // Reference clock pin, input side
  output logic                   port8_ref_clock_o,   // Reference clock pin, output side
  output logic                   port8_ref_clock_oe_o,// Reference clock pin enable
  input  wire logic              port8_speed_select_i,// Speed select pin, input side
  output logic                   port8_speed_select_o,// Speed select pin, output side
  output logic                   port8_speed_select_oe_o, // Speed select pin enable
  input  wire logic              port8_duplex_select_i,   // Duplex select pin
  output p8c_pkg::p8c_speed_t    link_speed_o,        // Latched link speed
  output logic                   mii_mode_o,          // High for MII, low for serial
  output logic                   speed_100_o,         // High for 100 Mbps
  output logic                   full_duplex_o,       // High for full duplex
  output logic                   mac_clk_tick_o,      // Port 8 MAC clock edge pulse
  output logic                   ref_lost_o           // Supplied reference stalled
);
  import p8c_pkg::*;

  p8c_speed_t speed_q;      // Latched speed selection
  logic       mii_q;        // Latched interface type
  p8c_dir_t   dir;          // Pin direction state
  p8c_dir_t   next_dir;     // Next direction
  logic       rmii_rise;    // RMII clock edge pulse
  logic       ref_rise;     // Supplied reference edge pulse
  logic       div_q;        // Divide-by-two toggle
  logic [7:0] idle_cnt;     // Cycles since last supplied edge

  // Speed-up when strap not the regular 100 Mbps code
  wire speedup = (speed_q != P8C_X1);
  wire drive   = (dir == P8C_DRIVE);

  // Catch straps while reset is held; hold afterwards
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      speed_q <= p8c_speed_t'(strap_speed_i);
      mii_q   <= strap_mii_i;
    end
  end

  // Direction from latched selection
  always_comb begin
    next_dir = speedup ? P8C_SENSE : P8C_DRIVE;
  end

  // Direction register, follows the latched straps in reset too
  // A fixed reset value would drive the pin for one cycle after reset in speed-up
  always_ff @(posedge clk_sys_i) begin
    dir <= next_dir;
  end

  // Edge detection on the RMII clock
  p8c_edge u_rmii_edge (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .level_i   (rmii_clk_i),
    .rise_o    (rmii_rise)
  );

  // Edge detection on the supplied reference
  p8c_edge u_ref_edge (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .level_i   (port8_ref_clock_i),
    .rise_o    (ref_rise)
  );

  // Divide RMII clock by two: toggle on each rising edge
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      div_q <= 1'h0;
    end else if (rmii_rise) begin
      div_q <= ~div_q;
    end
  end

  // Pin drive and MAC clock source
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      port8_ref_clock_o    <= 1'h0;
      port8_ref_clock_oe_o <= 1'h0;
      mac_clk_tick_o       <= 1'h0;
    end else begin
      port8_ref_clock_o    <= drive & div_q;
      port8_ref_clock_oe_o <= drive;
      mac_clk_tick_o       <= drive ? (rmii_rise & div_q) : ref_rise;
    end
  end

  // Watchdog on supplied reference presence
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || drive || ref_rise) begin
      idle_cnt <= 8'h00;
    end else if (idle_cnt != 8'(`P8C_REF_TIMEOUT_CYC)) begin
      idle_cnt <= idle_cnt + 8'h01;
    end
  end

  // Mode, speed and duplex outputs
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      link_speed_o            <= P8C_X1;
      mii_mode_o              <= 1'h0;
      speed_100_o             <= 1'h0;
      full_duplex_o           <= 1'h0;
      port8_speed_select_o    <= 1'h0;
      port8_speed_select_oe_o <= 1'h0;
      ref_lost_o              <= 1'h0;
    end else begin
      link_speed_o            <= speed_q;
      mii_mode_o              <= (mii_q == `P8C_IF_MII);
      speed_100_o             <= speedup | (port8_speed_select_i == `P8C_SPEED_100);
      full_duplex_o           <= (port8_duplex_select_i == `P8C_DUPLEX_FULL);
      port8_speed_select_o    <= `P8C_SPEED_100;
      port8_speed_select_oe_o <= speedup;
      ref_lost_o              <= ~drive & (idle_cnt == 8'(`P8C_REF_TIMEOUT_CYC));
    end
  end

  // Pin enabled exactly in regular mode
  chk_refclk_dir: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    ##1 port8_ref_clock_oe_o == $past(!speedup, 2) || $past(rst_i, 2))
    else $error("reference clock direction wrong");
  // Input mode never drives
  chk_ref_quiet: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    speedup |-> !port8_ref_clock_o && !port8_ref_clock_oe_o)
    else $error("reference pin driven in speed-up");
  // Divider toggles only after RMII edge
  chk_div_half: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    $changed(div_q) |-> $past(rmii_rise))
    else $error("divider toggled without edge");
  // Straps stable after reset
  chk_strap_hold: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    $stable(speed_q) && $stable(mii_q))
    else $error("strap latch changed");
  // Duplex decode, skipping the edge whose outputs were still in reset
  chk_duplex: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !$past(rst_i) |-> full_duplex_o == $past(port8_duplex_select_i))
    else $error("duplex decode wrong");
  // Speed decode in regular mode
  chk_speed: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !$past(rst_i) && !$past(speedup) |-> speed_100_o == $past(port8_speed_select_i))
    else $error("speed decode wrong");
  // Speed forced to 100 in speed-up
  chk_speed_force: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !$past(rst_i) && $past(speedup) |-> speed_100_o)
    else $error("speed not forced in speed-up");
  // Speed pin driven high only in speed-up
  chk_spd_pin: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !$past(rst_i) |-> (port8_speed_select_oe_o == $past(speedup)) && port8_speed_select_o)
    else $error("speed pin drive wrong");
  // Interface strap decode
  chk_mii: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !$past(rst_i) |-> mii_mode_o == $past(mii_q))
    else $error("interface mode wrong");
  // Speed strap reported
  chk_link_spd: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !$past(rst_i) |-> link_speed_o == $past(speed_q))
    else $error("link speed wrong");
  // Straps taken on the last reset edge
  chk_strap_catch: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    $past(rst_i) |-> speed_q == $past(strap_speed_i) && mii_q == $past(strap_mii_i))
    else $error("straps not latched in reset");
  // Speed-up MAC clock follows the supplied reference
  chk_tick_src: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !$past(rst_i) && !$past(drive) |-> mac_clk_tick_o == $past(ref_rise))
    else $error("MAC clock not from supplied reference");
  // No lost-reference flag while the pin is an output
  chk_lost_quiet: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    $past(drive) |-> !ref_lost_o)
    else $error("reference lost flagged in regular mode");

  // RMII edge taken while driving the pin
  sequence s_rmii_taken;
    rmii_rise && drive;
  endsequence
  // Divider moves next edge, pin shows it one edge later
  sequence s_div_moved;
    ##1 $changed(div_q) ##1 (port8_ref_clock_o == $past(div_q));
  endsequence
  // Full divide chain from RMII edge to pin
  chk_div_chain: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    s_rmii_taken |-> s_div_moved)
    else $error("divide chain broken");
endmodule

// file: verification/p8c_far_end.sv
// Far end model that supplies the port 8 reference clock
`timescale 1ns/1ns
module p8c_far_end (
  input  wire logic                run_i,   // Supply the clock
  input  wire p8c_pkg::p8c_speed_t speed_i, // Configured link speed
  output logic                     ref_o    // Supplied reference clock
);
  import p8c_pkg::*;
  logic ck = 1'h0;  // Free toggle
  int   hi_ns;      // High phase
  int   lo_ns;      // Low phase
  // Quarter of the data rate: 50, about 71, 100 MHz; unknown speed runs fastest
  always_comb begin
    if (speed_i == P8C_X2) begin
      hi_ns = 10;
      lo_ns = 10;
    end else if (speed_i == P8C_X3) begin
      hi_ns = 8;
      lo_ns = 6;
    end else begin
      hi_ns = 6;
      lo_ns = 4;
    end
  end
  // Odd start and even phases keep toggles clear of system clock edges
  initial begin
    #1;
    forever begin
      #(lo_ns) ck = 1'h1;
      #(hi_ns) ck = 1'h0;
    end
  end
  // Pull-up level while stopped
  assign ref_o = run_i ? ck : 1'h1;
endmodule

// file: verification/tb_port8_refclk_and_mode_select.sv
// Testbench for the port 8 reference clock and mode select
`timescale 1ns/1ns
module tb_port8_refclk_and_mode_select;
  import p8c_pkg::*;
  logic       clk_sys_i = 1'h0; // System clock
  logic       rst_i     = 1'h1; // Reset
  logic       rmii_clk  = 1'h0; // RMII clock, 50 MHz
  logic [1:0] strap_spd = 2'h3; // Speed straps
  logic       strap_mii = 1'h1; // Interface strap
  logic       far_run   = 1'h0; // Far end supplies clock
  logic       far_spd   = 1'h1; // Far end speed level
  logic       far_dup   = 1'h0; // Far end duplex level
  wire        ref_far, ref_o, ref_oe, spd_o, spd_oe, tick, lost, mii, s100, fdx;
  wire        ref_pin = ref_oe ? ref_o : ref_far; // Resolved pin
  wire        spd_pin = spd_oe ? spd_o : far_spd; // Resolved pin
  p8c_speed_t link;             // Latched speed
  int         n_mismatch = 0;   // Mismatches
  int         check_count = 0;  // Comparisons
  int         r;                // Reference rises
  int         t;                // MAC ticks
  // Clocks
  always #2 clk_sys_i = ~clk_sys_i;
  // RMII clock toggles on odd times, clear of system clock edges
  initial begin
    #1;
    forever #10 rmii_clk = ~rmii_clk;
  end
  p8c_refclk_mode p8c_refclk_mode_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .rmii_clk_i(rmii_clk),
    .strap_speed_i(strap_spd), .strap_mii_i(strap_mii), .port8_ref_clock_i(ref_pin),
    .port8_ref_clock_o(ref_o), .port8_ref_clock_oe_o(ref_oe), .port8_speed_select_i(spd_pin),
    .port8_speed_select_o(spd_o), .port8_speed_select_oe_o(spd_oe), .port8_duplex_select_i(far_dup),
    .link_speed_o(link), .mii_mode_o(mii), .speed_100_o(s100), .full_duplex_o(fdx),
    .mac_clk_tick_o(tick), .ref_lost_o(lost));
  p8c_far_end p8c_far_end_inst (.run_i(far_run), .speed_i(link), .ref_o(ref_far));
  // Compare and count
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %0t %h %h", $time, seen, exp);
    end
  endtask
  // Reset with straps, then move straps after release
  task automatic boot(input logic [1:0] s, input logic m);
    rst_i <= 1'h1;
    strap_spd <= s;
    strap_mii <= m;
    repeat (4) @(posedge clk_sys_i);
    rst_i <= 1'h0;
    strap_spd <= ~s;
    strap_mii <= ~m;
    repeat (3) @(posedge clk_sys_i);
    #1;
    chk(link, s);
    chk(mii, m);
  endtask
  // Count reference rises and ticks over 400 ns
  task automatic count();
    logic p;
    r = 0;
    t = 0;
    p = ref_o;
    repeat (100) begin
      @(posedge clk_sys_i);
      #1;
      r += (ref_o && !p);
      t += tick;
      p = ref_o;
    end
  endtask
  // Regular mode: drive RMII/2, decode speed and duplex
  task automatic t_regular();
    far_run <= 1'h0;
    boot(2'h3, 1'h1);
    chk(ref_oe, 1'h1);
    chk(spd_oe, 1'h0);
    count();
    chk(r >= 9 && r <= 11, 1'h1);
    chk(t >= 9 && t <= 11, 1'h1);
    chk(lost, 1'h0);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys_i);
      far_spd <= i[0];
      far_dup <= i[1];
      repeat (3) @(posedge clk_sys_i);
      #1;
      chk(s100, i[0]);
      chk(fdx, i[1]);
    end
  endtask
  // Speed-up: pin is input, MAC follows supplied clock
  task automatic t_speedup(input logic [1:0] s, input int e);
    @(posedge clk_sys_i);
    far_run <= 1'h1;
    boot(s, 1'h0);
    repeat (10) @(posedge clk_sys_i);
    #1;
    chk(ref_oe, 1'h0);
    chk(s100, 1'h1);
    chk(spd_oe, 1'h1);
    chk(spd_o, 1'h1);
    count();
    chk(r == 0, 1'h1);
    chk(t >= e - 2 && t <= e + 2, 1'h1);
    chk(lost, 1'h0);
    @(posedge clk_sys_i);
    far_run <= 1'h0;
    repeat (60) @(posedge clk_sys_i);
    #1;
    chk(lost, 1'h1);
  endtask
  // Verdict
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    t_regular();
    t_speedup(2'h2, 20);
    t_speedup(2'h1, 30);
    t_speedup(2'h0, 40);
    tally_and_finish();
  end
  // Watchdog
  initial begin
    #20000;
    n_mismatch++;
    tally_and_finish();
  end
endmodule
